// ### slr_reset_ctrl.sv
// Reset handling controller for a two-port serial storage link node.
`timescale 1ns/1ps

module slr_reset_ctrl #(
    parameter int unsigned WALK_WAIT_CYC = slr_pkg::WALK_WAIT_CYC,
    parameter int unsigned HOLD_CYC = slr_pkg::HOLD_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Link port status and received frames
    input wire logic [1:0][1:0] port_state_i,
    input wire logic [1:0] char_sync_i,
    input wire logic [1:0] tx_busy_i,
    input wire logic [1:0] tx_flag_i,
    input wire logic [1:0] rx_link_reset_i,
    input wire logic [1:0] rx_total_i,
    input wire logic [1:0] rx_abs_i,
    input wire logic [1:0] rx_for_node_i,
    // Link port requests
    output logic [1:0] ack_send_o,
    output logic [1:0] enter_check_o,
    output logic [1:0] tx_ctl_o,
    output logic [1:0] tx_ctl_abs_o,
    output logic [1:0] tx_link_reset_o,
    // Node reset actions
    output logic node_clear_o,
    output logic abs_reset_o,
    output logic begin_comm_o,
    output logic wrap_mode_o,
    output logic link_up_o,
    output logic cfg_allowed_o,
    // Web reset walk
    input wire logic reply_i,
    input wire logic known_id_i,
    input wire logic alert_op_i,
    input wire logic master_reconfig_i,
    output logic query_o,
    output logic mark_sel_o,
    output logic node_dead_o,
    output logic walk_prep_o,
    output logic walk_done_o
);

    slr_pkg::slr_state_t r;
    slr_pkg::slr_state_t n;
    logic [1:0] elig;
    logic [1:0] has_fwd;
    logic [1:0] tx_go;
    logic [1:0] lr_go;
    logic [1:0] lr_ok;
    logic wr;
    logic rd_setup;
    logic mapped;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // Per-port transmit and receive decisions.
    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            // Reset frames only in Enabled or Ready.
            // Enabled needs the FLAG run first.
            // Held while Disabled or Check; link-up not looked at.
            assign elig[p] = (port_state_i[p] == slr_pkg::PS_READY) |
                ((port_state_i[p] == slr_pkg::PS_ENABLED) &
                 (r.flag_cnt[p] >= slr_pkg::MIN_FLAGS));
            assign has_fwd[p] = r.fwd_busy & (r.fwd_port == 1'(p));
            // Send once the current frame is finished.
            assign tx_go[p] = elig[p] & ~tx_busy_i[p] &
                (r.tx_pend[p] | has_fwd[p]);
            assign tx_ctl_abs_o[p] = r.tx_pend[p] ? r.tx_abs[p] : r.fwd_abs;
            // Link reset leaves only from Check.
            assign lr_go[p] = r.lr_pend[p] & ~tx_busy_i[p] &
                (port_state_i[p] == slr_pkg::PS_CHECK);
            // Accept in Ready or Check, buffers not consulted.
            assign lr_ok[p] = rx_link_reset_i[p] &
                ((port_state_i[p] == slr_pkg::PS_READY) |
                 (port_state_i[p] == slr_pkg::PS_CHECK));

            // Assertions for this port.
            lr_ack_a: assert property (lr_ok[p] |=> ack_send_o[p])
                else $error("link reset not acknowledged");
            lr_check_a: assert property (
                lr_ok[p] && port_state_i[p] != slr_pkg::PS_CHECK
                |=> enter_check_o[p])
                else $error("link reset did not request Check");
            lr_origin_a: assert property (
                tx_link_reset_o[p] |-> port_state_i[p] == slr_pkg::PS_CHECK)
                else $error("link reset sent outside Check");
            tx_state_a: assert property (
                tx_ctl_o[p] |-> port_state_i[p] == slr_pkg::PS_READY ||
                port_state_i[p] == slr_pkg::PS_ENABLED)
                else $error("reset frame sent in Disabled or Check");
            tx_flags_a: assert property (
                tx_ctl_o[p] && port_state_i[p] == slr_pkg::PS_ENABLED
                |-> r.flag_cnt[p] == slr_pkg::MIN_FLAGS)
                else $error("reset frame sent before 200 FLAGs");
            tx_idle_a: assert property (tx_ctl_o[p] |-> !tx_busy_i[p])
                else $error("reset frame sent over a frame in progress");
        end
    endgenerate

    assign tx_ctl_o = tx_go;
    assign tx_link_reset_o = lr_go;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; the slave answers with no wait states.
    assign wr = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign mapped = (paddr_i == slr_pkg::ADDR_CTRL) |
        (paddr_i == slr_pkg::ADDR_CMD) | (paddr_i == slr_pkg::ADDR_STATUS) |
        (paddr_i == slr_pkg::ADDR_PCFG0) | (paddr_i == slr_pkg::ADDR_PCFG1);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic node_rst;
        logic rst_abs;
        logic link_rst;
        logic idx;
        node_rst = 1'b0;
        rst_abs = 1'b0;
        link_rst = 1'b0;
        idx = pwdata_i[slr_pkg::CMD_PORT];
        n = r;
        n.ack = 2'h0;
        n.chk = 2'h0;
        n.evt_clear = 1'b0;
        n.evt_abs = 1'b0;
        n.evt_begin = r.evt_clear;
        n.evt_wrap = 1'b0;
        n.evt_query = 1'b0;
        n.evt_sel = 1'b0;
        n.evt_dead = 1'b0;
        n.evt_prep = 1'b0;
        n.evt_done = 1'b0;

        for (int p = 0; p < 2; p++) begin
            // Count FLAGs sent since the port entered Enabled.
            if (port_state_i[p] != slr_pkg::PS_ENABLED) begin
                n.flag_cnt[p] = 8'h00;
            end else if (tx_flag_i[p] && r.flag_cnt[p] < slr_pkg::MIN_FLAGS) begin
                n.flag_cnt[p] = r.flag_cnt[p] + 8'h01;
            end
            // No credit or sequence strobe exists on this path.
            // Buffers and mode are left alone here.
            if (lr_ok[p]) begin
                n.ack[p] = 1'b1;
                n.chk[p] = port_state_i[p] != slr_pkg::PS_CHECK;
            end
            // Recognised in any state once synchronised.
            if (char_sync_i[p] && (rx_total_i[p] || rx_abs_i[p])) begin
                if (rx_for_node_i[p]) begin
                    node_rst = 1'b1;
                    link_rst = 1'b1;
                    rst_abs = rst_abs | rx_abs_i[p];
                end else if (!n.fwd_busy) begin
                    // One slot; a second frame is dropped.
                    // Only total and absolute resets enter the slot.
                    n.fwd_busy = 1'b1;
                    n.fwd_port = ~1'(p);
                    n.fwd_abs = rx_abs_i[p];
                end
            end
            if (tx_go[p]) begin
                if (r.tx_pend[p]) begin
                    n.tx_pend[p] = 1'b0;
                end else begin
                    n.fwd_busy = 1'b0;
                end
            end
            if (lr_go[p]) begin
                n.lr_pend[p] = 1'b0;
            end
        end

        // Register writes.
        if (wr) begin
            case (paddr_i)
                slr_pkg::ADDR_CTRL: begin
                    n.cfg_node = pwdata_i[slr_pkg::CTRL_CFG_NODE];
                    n.link_up = pwdata_i[slr_pkg::CTRL_LINK_UP];
                    n.walk_port = pwdata_i[slr_pkg::CTRL_WALK_PORT];
                end
                slr_pkg::ADDR_CMD: begin
                    if (pwdata_i[slr_pkg::CMD_TOTAL]) begin
                        n.tx_pend[idx] = 1'b1;
                        n.tx_abs[idx] = 1'b0;
                    end
                    if (pwdata_i[slr_pkg::CMD_ABS]) begin
                        n.tx_pend[idx] = 1'b1;
                        n.tx_abs[idx] = 1'b1;
                    end
                    if (pwdata_i[slr_pkg::CMD_LINK_RESET] &&
                        port_state_i[idx] == slr_pkg::PS_CHECK) begin
                        n.lr_pend[idx] = 1'b1;
                    end
                end
                slr_pkg::ADDR_PCFG0: begin
                    n.pcfg[0] = slr_pkg::slr_pcfg_t'(pwdata_i[25:0]);
                end
                slr_pkg::ADDR_PCFG1: begin
                    n.pcfg[1] = slr_pkg::slr_pcfg_t'(pwdata_i[25:0]);
                end
                default: begin
                end
            endcase
        end

        // Wrap mode first, absolute reset next.
        case (r.por)
            slr_pkg::POR_WRAP: begin
                n.evt_wrap = 1'b1;
                n.por = slr_pkg::POR_ABS;
            end
            slr_pkg::POR_ABS: begin
                node_rst = 1'b1;
                rst_abs = 1'b1;
                n.por = slr_pkg::POR_DONE;
            end
            default: begin
            end
        endcase

        // Web reset walk.
        if (r.wtmr != 24'h0) begin
            n.wtmr = r.wtmr - 24'h1;
        end
        case (r.walk)
            slr_pkg::W_IDLE: begin
                if (wr && paddr_i == slr_pkg::ADDR_CMD &&
                    pwdata_i[slr_pkg::CMD_WALK_START]) begin
                    // Table clear, self entry, disable, begin comms.
                    n.evt_prep = 1'b1;
                    n.link_up = 1'b0;
                    n.evt_begin = 1'b1;
                    n.walk = slr_pkg::W_PREP;
                end
            end
            slr_pkg::W_PREP: begin
                n.evt_query = 1'b1;
                n.wtmr = 24'(WALK_WAIT_CYC - 1);
                n.walk = slr_pkg::W_QUERY;
            end
            slr_pkg::W_QUERY: begin
                // Known node is marked and skipped.
                if (reply_i && known_id_i) begin
                    n.evt_sel = 1'b1;
                    n.walk = slr_pkg::W_NEXT;
                end else if (reply_i || r.wtmr == 24'h0) begin
                    n.tx_pend[r.walk_port] = 1'b1;
                    n.tx_abs[r.walk_port] = 1'b0;
                    n.wtmr = 24'(WALK_WAIT_CYC - 1);
                    n.walk = slr_pkg::W_TOTAL;
                end
            end
            slr_pkg::W_TOTAL: begin
                // Fall back to an absolute reset.
                if (alert_op_i) begin
                    n.walk = slr_pkg::W_NEXT;
                end else if (r.wtmr == 24'h0) begin
                    n.tx_pend[r.walk_port] = 1'b1;
                    n.tx_abs[r.walk_port] = 1'b1;
                    n.wtmr = 24'(WALK_WAIT_CYC - 1);
                    n.walk = slr_pkg::W_ABS;
                end
            end
            slr_pkg::W_ABS: begin
                if (alert_op_i) begin
                    n.walk = slr_pkg::W_NEXT;
                end else if (r.wtmr == 24'h0) begin
                    n.evt_dead = 1'b1;
                    n.walk = slr_pkg::W_NEXT;
                end
            end
            slr_pkg::W_NEXT: begin
                if (wr && paddr_i == slr_pkg::ADDR_CMD) begin
                    if (pwdata_i[slr_pkg::CMD_WALK_END]) begin
                        n.evt_done = 1'b1;
                        n.walk = slr_pkg::W_FINISH;
                    end else if (pwdata_i[slr_pkg::CMD_WALK_NEXT]) begin
                        n.evt_query = 1'b1;
                        n.wtmr = 24'(WALK_WAIT_CYC - 1);
                        n.walk = slr_pkg::W_QUERY;
                    end
                end
            end
            slr_pkg::W_FINISH: begin
                n.walk = slr_pkg::W_IDLE;
            end
            default: begin
                n.walk = slr_pkg::W_IDLE;
            end
        endcase

        // Configuration hold; a new reset wins over the release.
        if (r.hold) begin
            if (master_reconfig_i || r.hold_tmr == 31'h0) begin
                n.hold = 1'b0;
            end else begin
                n.hold_tmr = r.hold_tmr - 31'h1;
            end
        end
        if (link_rst && r.cfg_node) begin
            n.hold = 1'b1;
            n.hold_tmr = 31'(HOLD_CYC - 1);
        end

        // Node clear; per-port values; absolute reset.
        if (node_rst) begin
            n.evt_clear = 1'b1;
            n.evt_abs = rst_abs;
            n.link_up = 1'b0;
            n.lr_pend = 2'h0;
            n.pcfg[0] = slr_pkg::PCFG_RST;
            n.pcfg[1] = slr_pkg::PCFG_RST;
        end

        // Read data is captured in the setup cycle.
        if (rd_setup) begin
            case (paddr_i)
                slr_pkg::ADDR_CTRL: begin
                    n.prdata = {29'h0, r.walk_port, r.link_up, r.cfg_node};
                end
                slr_pkg::ADDR_STATUS: begin
                    n.prdata = {19'h0, r.walk, r.hold, r.fwd_busy,
                        r.lr_pend, r.tx_pend};
                end
                slr_pkg::ADDR_PCFG0: begin
                    n.prdata = {6'h0, r.pcfg[0]};
                end
                slr_pkg::ADDR_PCFG1: begin
                    n.prdata = {6'h0, r.pcfg[1]};
                end
                default: begin
                    n.prdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.por <= slr_pkg::POR_WRAP;
            r.walk <= slr_pkg::W_IDLE;
            r.pcfg <= {slr_pkg::PCFG_RST, slr_pkg::PCFG_RST};
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata_o = r.prdata;
    assign ack_send_o = r.ack;
    assign enter_check_o = r.chk;
    assign node_clear_o = r.evt_clear;
    assign abs_reset_o = r.evt_abs;
    assign begin_comm_o = r.evt_begin;
    assign wrap_mode_o = r.evt_wrap;
    assign link_up_o = r.link_up;
    assign cfg_allowed_o = ~r.hold;
    assign query_o = r.evt_query;
    assign mark_sel_o = r.evt_sel;
    assign node_dead_o = r.evt_dead;
    assign walk_prep_o = r.evt_prep;
    assign walk_done_o = r.evt_done;

    ////////////////////////////////////////////////////////////////////////
    // Node-level assertions.
    sequence s_clear;
        node_clear_o;
    endsequence
    sequence s_total_silent;
        r.walk == slr_pkg::W_TOTAL && r.wtmr == 24'h0 && !alert_op_i;
    endsequence

    clear_values_a: assert property (s_clear |->
        r.pcfg[0] == slr_pkg::PCFG_RST && r.pcfg[1] == slr_pkg::PCFG_RST &&
        !link_up_o)
        else $error("total reset left wrong port values");
    begin_comm_a: assert property (s_clear |=> begin_comm_o)
        else $error("begin communication not started");
    por_order_a: assert property (wrap_mode_o |=> abs_reset_o &&
        node_clear_o)
        else $error("power-on absolute reset missing after wrap");
    hold_start_a: assert property (
        char_sync_i[0] && rx_total_i[0] && rx_for_node_i[0] && r.cfg_node
        |=> !cfg_allowed_o)
        else $error("configuration hold not started");
    abs_fallback_a: assert property (s_total_silent |=>
        r.walk == slr_pkg::W_ABS && r.tx_pend[r.walk_port] &&
        r.tx_abs[r.walk_port])
        else $error("absolute reset not queued after silent total reset");
    known_skip_a: assert property (
        r.walk == slr_pkg::W_QUERY && reply_i && known_id_i
        |=> mark_sel_o && r.walk == slr_pkg::W_NEXT)
        else $error("known node not skipped");
    prep_first_a: assert property (walk_prep_o |=> query_o)
        else $error("query not issued after walk preparation");

endmodule : slr_reset_ctrl

// ### slr_pkg.sv
// Constants, types and register map of the serial link reset controller.
package slr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Port states as reported by each link port.
    localparam logic [1:0] PS_DISABLED = 2'h0;
    localparam logic [1:0] PS_ENABLED = 2'h1;
    localparam logic [1:0] PS_READY = 2'h2;
    localparam logic [1:0] PS_CHECK = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_PCFG0 = 12'h010;
    localparam logic [11:0] ADDR_PCFG1 = 12'h014;

    // Control register fields.
    localparam int CTRL_CFG_NODE = 0;
    localparam int CTRL_LINK_UP = 1;
    localparam int CTRL_WALK_PORT = 2;

    // Command register fields; all but CMD_PORT are write-one strobes.
    localparam int CMD_TOTAL = 0;
    localparam int CMD_ABS = 1;
    localparam int CMD_LINK_RESET = 2;
    localparam int CMD_PORT = 3;
    localparam int CMD_WALK_START = 4;
    localparam int CMD_WALK_NEXT = 5;
    localparam int CMD_WALK_END = 6;

    ////////////////////////////////////////////////////////////////////////
    // Per-port values loaded by a total reset.
    localparam logic [3:0] FIRST_QUOTA_RST = 4'h1;
    localparam logic [3:0] SECOND_QUOTA_RST = 4'h4;
    localparam logic BIT_A_RST = 1'b0;
    localparam logic EXTRA_DETAIL_RST = 1'b0;
    localparam logic [7:0] RECOVERY_COUNTER_RST = 8'h00;
    localparam logic [7:0] ALARM_THRESHOLD_RST = 8'h0a;

    // FLAG characters sent in Enabled before a reset frame may go out.
    localparam logic [7:0] MIN_FLAGS = 8'hc8;

    ////////////////////////////////////////////////////////////////////////
    // Timing at the 125 MHz node clock.
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned WALK_WAIT_MS = 125;
    localparam int unsigned HOLD_S = 10;
    localparam int unsigned WALK_WAIT_CYC = WALK_WAIT_MS * CLK_KHZ;
    localparam int unsigned HOLD_CYC = HOLD_S * 1000 * CLK_KHZ;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic [7:0] alarm_threshold;
        logic [7:0] recovery_counter;
        logic extra_detail_bit;
        logic bit_a;
        logic [3:0] second_quota;
        logic [3:0] first_quota;
    } slr_pcfg_t;

    localparam slr_pcfg_t PCFG_RST = '{
        alarm_threshold: ALARM_THRESHOLD_RST,
        recovery_counter: RECOVERY_COUNTER_RST,
        extra_detail_bit: EXTRA_DETAIL_RST,
        bit_a: BIT_A_RST,
        second_quota: SECOND_QUOTA_RST,
        first_quota: FIRST_QUOTA_RST
    };

    typedef enum logic [6:0] {
        W_IDLE = 7'h01,
        W_PREP = 7'h02,
        W_QUERY = 7'h04,
        W_TOTAL = 7'h08,
        W_ABS = 7'h10,
        W_NEXT = 7'h20,
        W_FINISH = 7'h40
    } slr_walk_t;

    typedef enum logic [2:0] {
        POR_WRAP = 3'h1,
        POR_ABS = 3'h2,
        POR_DONE = 3'h4
    } slr_por_t;

    typedef struct packed {
        logic cfg_node;
        logic link_up;
        logic walk_port;
        slr_pcfg_t [1:0] pcfg;
        logic [1:0][7:0] flag_cnt;
        logic [1:0] tx_pend;
        logic [1:0] tx_abs;
        logic [1:0] lr_pend;
        logic fwd_busy;
        logic fwd_port;
        logic fwd_abs;
        logic hold;
        logic [30:0] hold_tmr;
        slr_por_t por;
        slr_walk_t walk;
        logic [23:0] wtmr;
        logic [1:0] ack;
        logic [1:0] chk;
        logic evt_clear;
        logic evt_abs;
        logic evt_begin;
        logic evt_wrap;
        logic evt_query;
        logic evt_sel;
        logic evt_dead;
        logic evt_prep;
        logic evt_done;
        logic [31:0] prdata;
    } slr_state_t;

endpackage : slr_pkg

// ### slr_remote_port.sv
// Remote port model standing on the far side of both local ports.
`timescale 1ns/1ps
module slr_remote_port (
    // Commanded link condition
    input wire logic [1:0][1:0] state_i,
    input wire logic [1:0] busy_i,
    // Link status toward the node
    output logic [1:0][1:0] port_state_o,
    output logic [1:0] char_sync_o,
    output logic [1:0] tx_busy_o,
    output logic [1:0] tx_flag_o
);
    assign port_state_o = state_i;
    assign tx_busy_o = busy_i;
    // A FLAG goes out every cycle while a port idles in Enabled.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            char_sync_o[p] = state_i[p] != slr_pkg::PS_DISABLED;
            tx_flag_o[p] = state_i[p] == slr_pkg::PS_ENABLED;
        end
    end
endmodule : slr_remote_port

// ### slr_reset_ctrl_bench.sv
// Self-checking bench for the serial link reset controller.
`timescale 1ns/1ps
module slr_reset_ctrl_bench;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, rd, prd;
    logic [1:0][1:0] st = '0, ps;
    logic [1:0] busy = '0, rxl = '0, rxt = '0, rxa = '0, rxn = '0;
    logic [1:0] cs, txb, fl, ack, ec, txc, txa, lrt, ack_w, ec_w, txc_w;
    logic [1:0] txa_w, lrt_w;
    logic prdy, clr, absr, beg, wrap, lup, cfg, perr, qry, sel, dead, prep;
    logic done, er, prdy_w, clr_w, absr_w, beg_w, wrap_w, lup_w, cfg_w;
    logic perr_w, qry_w, sel_w, dead_w, prep_w, done_w;
    logic rep = 1'b0, kn = 1'b0, alr = 1'b0, rcf = 1'b0;
    logic [31:0] prd_w;
    int err_count = 0, cmp_count = 0, cyc = 0, n;
    slr_remote_port slr_remote_port_i (.state_i(st), .busy_i(busy),
        .port_state_o(ps), .char_sync_o(cs), .tx_busy_o(txb), .tx_flag_o(fl));
    slr_reset_ctrl #(.WALK_WAIT_CYC(20), .HOLD_CYC(30)) slr_reset_ctrl_i (
        .ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd_w),
        .pready_o(prdy_w), .pslverr_o(perr_w), .port_state_i(ps),
        .char_sync_i(cs), .tx_busy_i(txb), .tx_flag_i(fl),
        .rx_link_reset_i(rxl), .rx_total_i(rxt), .rx_abs_i(rxa),
        .rx_for_node_i(rxn), .ack_send_o(ack_w), .enter_check_o(ec_w),
        .tx_ctl_o(txc_w), .tx_ctl_abs_o(txa_w), .tx_link_reset_o(lrt_w),
        .node_clear_o(clr_w), .abs_reset_o(absr_w), .begin_comm_o(beg_w),
        .wrap_mode_o(wrap_w), .link_up_o(lup_w), .cfg_allowed_o(cfg_w),
        .reply_i(rep), .known_id_i(kn), .alert_op_i(alr),
        .master_reconfig_i(rcf), .query_o(qry_w), .mark_sel_o(sel_w),
        .node_dead_o(dead_w), .walk_prep_o(prep_w), .walk_done_o(done_w));
    // Outputs are taken mid-cycle, so a check at a rising edge sees the
    // value that the design showed up to that edge.
    always @(negedge clk) begin
        {prd, prdy, perr, ack, ec, txc, txa, lrt} <=
            {prd_w, prdy_w, perr_w, ack_w, ec_w, txc_w, txa_w, lrt_w};
        {clr, absr, beg, wrap, lup, cfg, qry, sel, dead, prep, done} <=
            {clr_w, absr_w, beg_w, wrap_w, lup_w, cfg_w, qry_w, sel_w,
             dead_w, prep_w, done_w};
    end
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic tk(input int k);
        repeat (k) @(posedge clk);
    endtask : tk
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        tk(1);
        pen <= 1'b1;
        do tk(1); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic t_link();
        st <= {slr_pkg::PS_CHECK, slr_pkg::PS_READY};
        rxl <= 2'h3;
        tk(1);
        rxl <= 2'h0;
        tk(1);
        chk("ack", {ec, ack}, 4'h7);
        st <= '0;
        rxl <= 2'h3;
        tk(1);
        rxl <= 2'h0;
        tk(1);
        chk("ack_off", ack, 2'h0);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h4);
        st[0] <= slr_pkg::PS_CHECK;
        tk(1);
        chk("lr_refused", lrt, 2'h0);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h4);
        tk(1);
        chk("lr_sent", lrt, 2'h1);
    endtask : t_link
    task automatic t_tx();
        st <= {slr_pkg::PS_CHECK, slr_pkg::PS_READY};
        busy <= 2'h1;
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h1);
        tk(1);
        chk("tx_busy", txc, 2'h0);
        busy <= 2'h0;
        tk(1);
        chk("tx_tot", {txa, txc}, 4'h1);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'ha);
        tk(2);
        chk("tx_chk", txc, 2'h0);
        st[1] <= slr_pkg::PS_READY;
        tk(1);
        chk("tx_abs", {txa, txc}, 4'ha);
        st[0] <= slr_pkg::PS_DISABLED;
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h1);
        st[0] <= slr_pkg::PS_ENABLED;
        n = 0;
        do begin
            tk(1);
            n++;
        end while (txc[0] !== 1'b1 && n < 400);
        chk("flags", 32'(n >= 201 && n < 400), 32'h1);
    endtask : t_tx
    task automatic t_node();
        apb(1'b1, slr_pkg::ADDR_CTRL, 32'h3);
        tk(1);
        apb(1'b1, slr_pkg::ADDR_PCFG0, 32'h3ff_ffff);
        rxn <= 2'h1;
        rxt <= 2'h1;
        tk(1);
        rxt <= 2'h0;
        tk(1);
        chk("total", {clr, absr, lup, cfg}, 4'h8);
        tk(1);
        chk("begin", beg, 1'b1);
        tk(28);
        chk("hold", cfg, 1'b0);
        tk(1);
        chk("release", cfg, 1'b1);
        apb(1'b0, slr_pkg::ADDR_PCFG0, 32'h0);
        chk("pcfg", rd, 32'h0028_0041);
        rxa <= 2'h1;
        tk(1);
        rxa <= 2'h0;
        tk(1);
        chk("abs", {clr, absr, cfg}, 3'h6);
        rcf <= 1'b1;
        tk(1);
        rcf <= 1'b0;
        tk(1);
        chk("reconfig", cfg, 1'b1);
    endtask : t_node
    task automatic t_fwd();
        st[1] <= slr_pkg::PS_CHECK;
        rxn <= 2'h0;
        rxt <= 2'h1;
        tk(1);
        rxt <= 2'h2;
        tk(1);
        rxt <= 2'h0;
        tk(3);
        chk("held", txc, 2'h0);
        st[1] <= slr_pkg::PS_READY;
        tk(1);
        chk("fwd", {txa, txc}, 4'h2);
        tk(1);
        chk("drop", txc, 2'h0);
    endtask : t_fwd
    task automatic t_walk();
        apb(1'b1, slr_pkg::ADDR_CTRL, 32'h3);
        tk(1);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h10);
        tk(1);
        chk("prep", {prep, beg, lup}, 3'h6);
        tk(1);
        chk("query", qry, 1'b1);
        rep <= 1'b1;
        kn <= 1'b1;
        tk(1);
        rep <= 1'b0;
        kn <= 1'b0;
        tk(1);
        chk("skip", sel, 1'b1);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h20);
        tk(21);
        chk("walk_tot", {txa, txc}, 4'h1);
        tk(20);
        chk("walk_abs", {txa, txc}, 4'h5);
        tk(20);
        chk("dead", dead, 1'b1);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h20);
        rep <= 1'b1;
        tk(1);
        rep <= 1'b0;
        alr <= 1'b1;
        tk(1);
        alr <= 1'b0;
        apb(1'b0, slr_pkg::ADDR_STATUS, 32'h0);
        chk("alert", rd, 32'h0000_0800);
        tk(1);
        apb(1'b1, slr_pkg::ADDR_CMD, 32'h40);
        tk(1);
        chk("done", done, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("slverr", er, 1'b1);
    endtask : t_walk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        tk(5);
        rstn <= 1'b1;
        tk(2);
        chk("wrap", wrap, 1'b1);
        tk(1);
        chk("por_abs", {clr, absr}, 2'h3);
        t_link();
        t_tx();
        t_node();
        t_fwd();
        t_walk();
        give_verdict();
    end
endmodule : slr_reset_ctrl_bench
